// file: sfr_pkg.sv
// Constants, register map and state encoding for the fast read path.
// Assumes a 32-bit APB register bus and a byte-wide array read port.
package sfr_pkg;

    // Opcodes taken by this path
    localparam logic [7:0] OP_FAST_READ      = 8'h0b;
    localparam logic [7:0] OP_FAST_READ_WIDE = 8'h0c;
    localparam logic [7:0] OP_DUAL_IO        = 8'hbb;
    localparam logic [7:0] OP_DUAL_IO_WIDE   = 8'hbc;
    localparam logic [7:0] OP_QUAD_IO        = 8'heb;
    localparam logic [7:0] OP_UNIQUE_ID      = 8'h4b;
    localparam logic [7:0] OP_INFO_ROW       = 8'h68;

    // Phase lengths in serial clocks
    localparam logic [5:0] OPC_CLKS_SINGLE = 6'h08;
    localparam logic [5:0] OPC_CLKS_QUAD   = 6'h02;
    localparam logic [5:0] ADDR3_BITS      = 6'h18;
    localparam logic [5:0] ADDR4_BITS      = 6'h20;
    localparam logic [5:0] MODE_CLKS       = 6'h04;
    localparam logic [5:0] MODE_NIB_CLK    = 6'h01;
    localparam logic [3:0] MODE_CONT_NIB   = 4'ha;
    localparam logic [31:0] ADDR3_MASK     = 32'h00ffffff;

    // Lane shift: width on the data lines is 1 << shift
    localparam logic [1:0] LANE_SH_1 = 2'h0;
    localparam logic [1:0] LANE_SH_2 = 2'h1;
    localparam logic [1:0] LANE_SH_4 = 2'h2;
    localparam logic [3:0] OE_NONE   = 4'hf;
    localparam logic [3:0] OE_LANE1  = 4'hd;
    localparam logic [3:0] OE_LANE2  = 4'hc;
    localparam logic [3:0] OE_LANE4  = 4'h0;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Register byte offsets
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_DUMMY  = 12'h004;
    localparam logic [11:0] REG_STATUS = 12'h008;
    localparam logic [11:0] REG_ADDR   = 12'h00c;

    // Control fields
    localparam int CTRL_EXT_ADDR = 0;
    localparam int CTRL_QUAD_CMD = 1;
    localparam int CTRL_QE       = 2;
    localparam int CTRL_DTR      = 3;
    localparam int CTRL_HOLD_RST = 4;
    localparam int CTRL_WIP      = 5;
    localparam int CTRL_W        = 6;
    localparam logic [5:0] CTRL_RST = 6'h00;

    // Dummy count fields, four bits each
    localparam int DUMMY_SINGLE_LSB = 0;
    localparam int DUMMY_QUAD_LSB   = 4;
    localparam int DUMMY_DUAL_LSB   = 8;
    localparam logic [3:0] DUMMY_SINGLE_DEF = 4'h8;
    localparam logic [3:0] DUMMY_QUAD_DEF   = 4'h6;
    localparam logic [3:0] DUMMY_DUAL_DEF   = 4'h4;

    typedef enum logic [2:0] {
        SFR_IDLE    = 3'h0,
        SFR_CMD     = 3'h1,
        SFR_ADDR    = 3'h3,
        SFR_DUMMY   = 3'h2,
        SFR_DATA    = 3'h6,
        SFR_DISCARD = 3'h7
    } sfr_state_e;

endpackage

// file: sfr_fast_read.sv
// Fast read command path of a serial NOR flash, device side.
// Assumes the serial pins come from another domain and are oversampled by
// pclk (at least 8 pclk per half serial clock), and that the array port
// returns its byte on the cycle after arr_req.
// Function
// RULE1: 0Bh address width follows flag; 0Ch four bytes
// RULE2: Single line inputs sampled rising; dummy default eight
// RULE3: Data shifted out on falling edges
// RULE4: Address increments per byte, wraps to zero
// RULE5: Chip select high ends read, returns idle
// RULE6: Reads while write busy are discarded
// RULE7: Four-line mode: 2/6/8 clocks, dummy six
// RULE8: Four-line data on all lanes, same rules
// RULE9: EBh, 4Bh, 68h use four-line framing
// RULE10: Hold pauses while clock low, state kept
// RULE11: During hold output floats, inputs ignored
// RULE12: Hold disabled by DTR, QE, reset pin
// RULE13: Dual I/O address two bits, MSB line 1
// RULE14: Dual I/O dummy default four clocks
// RULE15: Dual I/O data two bits per fall
// RULE16: Mode byte in first four dummy clocks
// RULE17: Nibble 1010 enters continuous read, else exits
// RULE18: Dummy count includes mode byte clocks
// RULE19: Leaving continuous read keeps line mode setting
// RULE20: Host gives enough dummy, floats low nibble
// RULE21: Wide address decodes bits 27 to 0
// RULE22: Early deselect abandons command without side effects
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps

module sfr_fast_read
    import sfr_pkg::*;
#(
    parameter int ARRAY_AW = 28
)
(
    input  wire logic                pclk,     // System clock
    input  wire logic                presetn,  // Async reset, active low
    input  wire logic [11:0]         paddr,    // APB address
    input  wire logic                psel,     // APB select
    input  wire logic                penable,  // APB enable
    input  wire logic                pwrite,   // APB direction
    input  wire logic [31:0]         pwdata,   // APB write data
    output logic      [31:0]         prdata,   // APB read data
    output logic                     pready,   // APB ready
    output logic                     pslverr,  // APB error
    input  wire logic                cs_n,     // Chip select pin
    input  wire logic                sck,      // Serial clock pin
    input  wire logic [3:0]          io_in,    // Data lines in
    output logic      [3:0]          io_out,   // Data lines out
    output logic      [3:0]          io_oe_n,  // Data line enables
    output logic      [ARRAY_AW-1:0] arr_addr, // Array read address
    output logic                     arr_req,  // Array read strobe
    input  wire logic [7:0]          arr_data  // Array read byte
);

    // Registers
    logic [CTRL_W-1:0] ctrl;
    logic [3:0]        dum_single;
    logic [3:0]        dum_quad;
    logic [3:0]        dum_dual;

    // Synchronisers
    logic       cs_m, cs_s, cs_d;
    logic       sck_m, sck_s, sck_d;
    logic [3:0] io_m, io_s;

    // Engine
    sfr_state_e        state;
    sfr_state_e        next_state;
    logic [5:0]        cnt;
    logic [31:0]       sreg;
    logic [1:0]        lane_sh;
    logic              wide;
    logic              dual;
    logic              cont_mode;
    logic              pend_cont;
    logic              hold_act;
    logic [ARRAY_AW-1:0] addr;
    logic              req_d;
    logic [7:0]        nbyte;
    logic [7:0]        dout;
    logic [3:0]        dbits;
    logic              drv;

    wire logic four_line_command_mode     = ctrl[CTRL_QUAD_CMD];
    wire logic write_in_progress_flag     = ctrl[CTRL_WIP];
    wire logic ext     = ctrl[CTRL_EXT_ADDR];
    wire logic hold_ok = ~four_line_command_mode & ~ctrl[CTRL_QE] & ~ctrl[CTRL_DTR]
                         & ~ctrl[CTRL_HOLD_RST];            // RULE12

    // APB decode
    wire logic hit_ctrl   = (paddr == REG_CTRL);
    wire logic hit_dummy  = (paddr == REG_DUMMY);
    wire logic hit_status = (paddr == REG_STATUS);
    wire logic hit_addr   = (paddr == REG_ADDR);
    wire logic addr_hit   = hit_ctrl | hit_dummy | hit_status | hit_addr;
    wire logic setup      = psel & ~penable;
    wire logic wr_en      = psel & penable & pready & pwrite;
    wire logic [31:0] rd_mux =
        hit_ctrl   ? {26'h0, ctrl} :
        hit_dummy  ? {20'h0, dum_dual, dum_quad, dum_single} :
        hit_status ? {27'h0, hold_act, cont_mode, state} :
        hit_addr   ? 32'(addr) : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & ~addr_hit;
            if (setup)
                prdata <= pwrite ? 32'h0 : rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl       <= CTRL_RST;
            dum_single <= DUMMY_SINGLE_DEF;                  // RULE2
            dum_quad   <= DUMMY_QUAD_DEF;                    // RULE7
            dum_dual   <= DUMMY_DUAL_DEF;                    // RULE14
        end
        else if (wr_en && hit_ctrl)
            ctrl <= pwdata[CTRL_W-1:0];
        else if (wr_en && hit_dummy)
        begin
            dum_single <= pwdata[DUMMY_SINGLE_LSB +: 4];
            dum_quad   <= pwdata[DUMMY_QUAD_LSB +: 4];
            dum_dual   <= pwdata[DUMMY_DUAL_LSB +: 4];
        end
    end

    // Pin synchronisers; logic reads the second stage, and the third stage only for cs and sck edge detection
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {cs_m, cs_s, cs_d}    <= 3'h7;
            {sck_m, sck_s, sck_d} <= 3'h0;
            io_m                  <= 4'hf;
            io_s                  <= 4'hf;
        end
        else
        begin
            {cs_m, cs_s, cs_d}    <= {cs_n, cs_m, cs_s};
            {sck_m, sck_s, sck_d} <= {sck, sck_m, sck_s};
            io_m                  <= io_in;
            io_s                  <= io_m;
        end
    end

    // Hold is only sampled while the clock is low, so a clock edge racing
    // the hold pin cannot slip a bit in or out.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_act <= 1'b0;
        else if (cs_s || !hold_ok)
            hold_act <= 1'b0;                               // RULE12
        else if (!sck_s)
            hold_act <= ~io_s[3];                           // RULE10
    end

    // Serial events; edges are swallowed during hold
    wire logic act       = ~cs_s & ~hold_act;               // RULE11
    wire logic rise      = act & sck_s & ~sck_d;            // RULE2
    wire logic fall      = act & ~sck_s & sck_d;            // RULE3
    wire logic start     = ~cs_s & cs_d;
    wire logic data_fall = fall & (state == SFR_DATA);

    wire logic [31:0] shift_in =
        (lane_sh == LANE_SH_4) ? {sreg[27:0], io_s} :       // RULE7
        (lane_sh == LANE_SH_2) ? {sreg[29:0], io_s[1:0]} :  // RULE13
                                 {sreg[30:0], io_s[0]};

    // Opcode decode
    wire logic [7:0] opc    = shift_in[7:0];
    wire logic is_frd       = (opc == OP_FAST_READ);
    wire logic is_frd_w     = (opc == OP_FAST_READ_WIDE);
    wire logic is_dio       = (opc == OP_DUAL_IO);
    wire logic is_dio_w     = (opc == OP_DUAL_IO_WIDE);
    wire logic is_qio       = (opc == OP_QUAD_IO);
    wire logic is_id        = (opc == OP_UNIQUE_ID) | (opc == OP_INFO_ROW);
    wire logic op_ok        = four_line_command_mode ? (is_frd | is_frd_w | is_qio | is_id)
                                  : (is_frd | is_frd_w | is_dio | is_dio_w);
    wire logic op_dual      = ~four_line_command_mode & (is_dio | is_dio_w);
    // Id and info-row reads always take three address bytes
    wire logic op_wide      = is_frd_w | is_dio_w
                              | (ext & (is_frd | is_dio | is_qio)); // RULE1
    wire logic [1:0] op_lane = four_line_command_mode ? LANE_SH_4 :
                               op_dual ? LANE_SH_2 : LANE_SH_1;    // RULE9

    // Phase lengths
    wire logic [5:0] opc_len  = four_line_command_mode ? OPC_CLKS_QUAD : OPC_CLKS_SINGLE;
    wire logic [5:0] addr_len = (wide ? ADDR4_BITS : ADDR3_BITS) >> lane_sh;
    wire logic [5:0] dual_cfg = {2'h0, dum_dual};
    // Mode clocks are part of the dummy count, never fewer than them
    wire logic [5:0] dummy_len =
        dual ? ((dual_cfg < MODE_CLKS) ? MODE_CLKS : dual_cfg) : // RULE18
        four_line_command_mode  ? {2'h0, dum_quad} : {2'h0, dum_single};
    wire logic [5:0] cnt_inc  = cnt + 6'h01;

    wire logic cmd_last  = rise & (state == SFR_CMD) & (cnt_inc == opc_len);
    wire logic addr_last = rise & (state == SFR_ADDR) & (cnt_inc == addr_len);
    wire logic dum_last  = rise & (state == SFR_DUMMY)
                           & (cnt_inc == dummy_len);
    wire logic no_dummy  = (dummy_len == 6'h00);
    wire logic enter_data = (addr_last & no_dummy) | dum_last;
    wire logic mode_clk  = rise & dual & (state == SFR_DUMMY)
                           & (cnt == MODE_NIB_CLK);         // RULE16

    // Top address bits beyond the array are dropped
    wire logic [ARRAY_AW-1:0] addr_cap =
        ARRAY_AW'(wide ? shift_in : (shift_in & ADDR3_MASK)); // RULE21
    wire logic [ARRAY_AW-1:0] fetch_addr = addr_last ? addr_cap : addr;
    wire logic byte_load = data_fall & (dbits == 4'h0);
    wire logic [3:0] lane_w = 4'h1 << lane_sh;
    wire logic [7:0] src = (dbits == 4'h0) ? nbyte : dout;
    wire logic [3:0] next_io =
        (lane_sh == LANE_SH_4) ? src[7:4] :                 // RULE8
        (lane_sh == LANE_SH_2) ? {2'h0, src[7:6]} :         // RULE15
                                 {2'h0, src[7], 1'b0};
    wire logic [3:0] oe_pat =
        (lane_sh == LANE_SH_4) ? OE_LANE4 :
        (lane_sh == LANE_SH_2) ? OE_LANE2 : OE_LANE1;

    always_comb
    begin
        next_state = state;
        case (state)
            SFR_IDLE:
                if (start)
                    next_state = cont_mode ? (write_in_progress_flag ? SFR_DISCARD : SFR_ADDR)
                                           : SFR_CMD;
            SFR_CMD:
                if (cmd_last)
                    next_state = (write_in_progress_flag | ~op_ok) ? SFR_DISCARD   // RULE6
                                                : SFR_ADDR;
            SFR_ADDR:
                if (addr_last)
                    next_state = no_dummy ? SFR_DATA : SFR_DUMMY;
            SFR_DUMMY:
                if (dum_last)
                    next_state = SFR_DATA;
            SFR_DATA:    next_state = SFR_DATA;
            SFR_DISCARD: next_state = SFR_DISCARD;
            default:     next_state = SFR_IDLE;
        endcase
        if (cs_s)
            next_state = SFR_IDLE;                          // RULE5 RULE22
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= SFR_IDLE;
            cnt   <= 6'h00;
        end
        else
        begin
            state <= next_state;
            if (cs_s || start || cmd_last || addr_last || dum_last)
                cnt <= 6'h00;
            else if (rise)
                cnt <= cnt_inc;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sreg <= 32'h0;
        else if (start || cmd_last || addr_last)
            sreg <= 32'h0;
        else if (rise)
            sreg <= shift_in;
    end

    // Continuous read starts straight at the address on dual lanes and
    // leaves the single/four-line setting alone.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lane_sh <= LANE_SH_1;
            wide    <= 1'b0;
            dual    <= 1'b0;
        end
        else if (start && state == SFR_IDLE)
        begin
            lane_sh <= cont_mode ? LANE_SH_2 :
                       (four_line_command_mode ? LANE_SH_4 : LANE_SH_1);       // RULE19
            dual    <= cont_mode;
        end
        else if (cmd_last)
        begin
            lane_sh <= op_lane;
            wide    <= op_wide;                             // RULE1
            dual    <= op_dual;
        end
    end

    // Mode nibble is only committed once data starts, so an early
    // deselect leaves continuous read untouched.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pend_cont <= 1'b0;
            cont_mode <= 1'b0;
        end
        else
        begin
            if (mode_clk)
                pend_cont <= (shift_in[3:0] == MODE_CONT_NIB);
            if (enter_data && dual)
                cont_mode <= pend_cont;                     // RULE17 RULE22
        end
    end

    // Array fetch runs one byte ahead of the shifter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr     <= '0;
            arr_addr <= '0;
            arr_req  <= 1'b0;
            req_d    <= 1'b0;
            nbyte    <= 8'h00;
        end
        else
        begin
            req_d   <= arr_req;
            arr_req <= enter_data | byte_load;
            if (addr_last)
                addr <= addr_cap;
            if (enter_data || byte_load)
            begin
                arr_addr <= fetch_addr;
                addr     <= fetch_addr + 1'b1;              // RULE4
            end
            if (req_d)
                nbyte <= arr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dout   <= 8'h00;
            dbits  <= 4'h0;
            drv    <= 1'b0;
            io_out <= 4'h0;
        end
        else if (cs_s || start || enter_data)
        begin
            dbits <= 4'h0;
            drv   <= 1'b0;
        end
        else if (data_fall)
        begin
            drv    <= 1'b1;
            dout   <= src << lane_w;
            dbits  <= (dbits == 4'h0) ? BYTE_BITS - lane_w
                                      : dbits - lane_w;
            io_out <= next_io;                              // RULE3
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            io_oe_n <= OE_NONE;
        else if (cs_s || hold_act || !(drv || data_fall))
            io_oe_n <= OE_NONE;                             // RULE5 RULE11
        else
            io_oe_n <= oe_pat;
    end

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_mode_taken;
        mode_clk && (shift_in[3:0] == MODE_CONT_NIB);
    endsequence

    sequence s_data_entry;
        !cs_s && enter_data && dual;
    endsequence

    a_deselect_idle: assert property (cs_s |=> state == SFR_IDLE) // RULE5
        else $error("state not idle after deselect");
    a_deselect_float: assert property (cs_s |=> io_oe_n == OE_NONE) // RULE5
        else $error("lines driven after deselect");
    a_busy_discard: assert property (cmd_last && write_in_progress_flag && !cs_s // RULE6
        |=> state == SFR_DISCARD)
        else $error("read accepted while busy");
    a_addr_step: assert property (byte_load && !cs_s // RULE4
        |=> addr == ARRAY_AW'($past(addr) + 1'b1))
        else $error("address not advanced by one");
    a_cont_enter: assert property (s_mode_taken ##[1:400] s_data_entry // RULE17
        |=> cont_mode)
        else $error("continuous read not entered");
    a_hold_float: assert property (hold_act |=> io_oe_n[1]) // RULE11
        else $error("output driven during hold");
    a_hold_gate: assert property (!hold_ok |=> !hold_act) // RULE12
        else $error("hold active while disabled");
    a_quad_lanes: assert property (data_fall && lane_sh == LANE_SH_4 // RULE8
        && !cs_s |=> io_oe_n == OE_LANE4)
        else $error("four-line data not on all lanes");
    a_fall_only: assert property ($changed(io_out) |-> $past(data_fall)) // RULE3
        else $error("data changed off a falling edge");

endmodule

// file: sfr_array_model.sv
// Array read port model for the fast read path bench.
// Assumes the fetch strobe is a pclk pulse and the byte is sampled the
// cycle after it.
`timescale 1ns/1ps

module sfr_array_model
(
    input  wire logic        pclk,     // System clock
    input  wire logic        presetn,  // Async reset, active low
    input  wire logic [27:0] arr_addr, // Fetch address
    input  wire logic        arr_req,  // Fetch strobe
    output logic      [7:0]  arr_data  // Fetched byte
);
    // Between fetches the byte flips each cycle, so a late sample shows up
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            arr_data <= 8'h00;
        else if (arr_req)
            arr_data <= arr_addr[7:0] + arr_addr[27:20];
        else
            arr_data <= ~arr_data;
endmodule

// file: test_serial_flash_fast_read_path.sv
// Self-checking bench: APB master, serial host tasks and array model.
// Assumes the serial clock is 16 pclk long and mode 3 idle (high).
`timescale 1ns/1ps

module test_serial_flash_fast_read_path;
    import sfr_pkg::*;

    logic        pclk;
    logic        presetn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cs_n;
    logic        sck;
    logic [3:0]  io_in;
    logic [3:0]  io_out;
    logic [3:0]  io_oe_n;
    logic [27:0] arr_addr;
    logic        arr_req;
    logic [7:0]  arr_data;
    logic [31:0] rd;
    logic        rerr;
    logic [3:0]  oe_seen;
    int          errors;
    int          cmp_count;

    sfr_fast_read u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cs_n(cs_n),
        .sck(sck), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n),
        .arr_addr(arr_addr), .arr_req(arr_req), .arr_data(arr_data));

    sfr_array_model u_array (.pclk(pclk), .presetn(presetn),
        .arr_addr(arr_addr), .arr_req(arr_req), .arr_data(arr_data));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [7:0] exp_byte(input logic [27:0] a);
        return a[7:0] + a[27:20];
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; n < 16 && pready !== 1'b1; n++)
            @(posedge pclk);
        if (n == 16)
        begin
            errors++;
            tally_and_finish();
        end
        rd = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never drives psel in this step
        @(posedge pclk);
    endtask

    // One serial clock; lines are looked at just before the rising edge
    task automatic sclk(input logic [3:0] v, output logic [3:0] r);
        sck   <= 1'b0;
        io_in <= v;
        repeat (8) @(posedge pclk);
        r = io_out;
        oe_seen = io_oe_n;
        sck <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask

    // Unused lanes carry a changing pattern; io3 stays high off quad
    task automatic send(input logic [31:0] v, input int n, input int w);
        logic [3:0] nib;
        logic [3:0] r;
        repeat (n)
        begin
            nib = (w == 4) ? 4'h0 : {1'b1, v[2:0]};
            for (int j = w - 1; j >= 0; j--)
            begin
                nib[j] = v[31];
                v = v << 1;
            end
            sclk(nib, r);
        end
    endtask

    task automatic rx(input logic [27:0] a, input int nb, input int w,
                      input logic [3:0] oe);
        logic [7:0] b;
        logic [3:0] r;
        for (int i = 0; i < nb; i++)
        begin
            for (int k = 0; k < 8 / w; k++)
            begin
                sclk(4'h8, r);
                chk({28'h0, oe_seen}, {28'h0, oe});
                b = (w == 1) ? {b[6:0], r[1]} :
                    (w == 2) ? {b[5:0], r[1:0]} : {b[3:0], r};
            end
            if (oe != OE_NONE)
                chk({24'h0, b}, {24'h0, exp_byte(a + 28'(i))});
        end
    endtask

    // A zero opcode leaves the opcode out, as in continuous read
    task automatic frame(input logic [7:0] op, input int ow,
                         input logic [31:0] a, input int nab, input int w,
                         input logic [31:0] dv, input int nd,
                         input logic [3:0] oe);
        logic [3:0] r;
        cs_n <= 1'b0;
        repeat (4) @(posedge pclk);
        if (op != 8'h00)
            send({op, 24'h0}, 8 / ow, ow);
        send(a << (32 - 8 * nab), 8 * nab / w, w);
        // Mode clocks fill the whole dummy: the low mode nibble is floated
        if (w == 2 && nd == 4)
        begin
            send(dv, 2, w);
            repeat (2) sclk({1'b1, 3'hz}, r);
        end
        else
            send(dv, nd, w);
        rx(a[27:0], 2, w, oe);
        cs_n <= 1'b1;
        repeat (8) @(posedge pclk);
        chk({28'h0, io_oe_n}, {28'h0, OE_NONE});
    endtask

    task automatic t_regs();
        apb(1'b0, REG_DUMMY, 32'h0);
        chk(rd, 32'h0000_0468);
        apb(1'b1, REG_STATUS, 32'hffff_ffff);
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        $display("Test registers done");
    endtask

    task automatic t_single();
        apb(1'b1, REG_CTRL, 32'h0);
        frame(OP_FAST_READ, 1, 32'h0012_34ff, 3, 1, 0, 8, OE_LANE1);
        apb(1'b1, REG_CTRL, 32'h1);
        frame(OP_FAST_READ, 1, 32'hffff_ffff, 4, 1, 0, 8, OE_LANE1);
        apb(1'b1, REG_CTRL, 32'h0);
        apb(1'b1, REG_DUMMY, 32'h463);
        frame(OP_FAST_READ_WIDE, 1, 32'h3000_0102, 4, 1, 0, 3, OE_LANE1);
        apb(1'b1, REG_DUMMY, 32'h468);
        apb(1'b1, REG_CTRL, 32'h20);
        frame(OP_FAST_READ, 1, 32'h0000_0100, 3, 1, 0, 8, OE_NONE);
        $display("Test single line done");
    endtask

    task automatic t_quad();
        logic [7:0] ops [4] = '{OP_FAST_READ, OP_QUAD_IO, OP_UNIQUE_ID,
                                OP_INFO_ROW};
        apb(1'b1, REG_CTRL, 32'h2);
        foreach (ops[i])
            frame(ops[i], 4, 32'h0000_4a7f, 3, 4, 0, 6, OE_LANE4);
        apb(1'b1, REG_CTRL, 32'h3);
        frame(OP_UNIQUE_ID, 4, 32'h0000_1234, 3, 4, 0, 6, OE_LANE4);
        frame(OP_FAST_READ, 4, 32'h0abc_dfff, 4, 4, 0, 6, OE_LANE4);
        $display("Test four line done");
    endtask

    task automatic t_dual();
        apb(1'b1, REG_CTRL, 32'h0);
        frame(OP_DUAL_IO, 1, 32'h0055_aa10, 3, 2, 32'ha000_0000, 4,
              OE_LANE2);
        apb(1'b0, REG_STATUS, 32'h0);
        chk({31'h0, rd[3]}, 32'h1);
        frame(8'h00, 1, 32'h0001_0203, 3, 2, 32'h5f00_0000, 4,
              OE_LANE2);
        apb(1'b0, REG_STATUS, 32'h0);
        chk({31'h0, rd[3]}, 32'h0);
        frame(OP_FAST_READ, 1, 32'h0000_0777, 3, 1, 0, 8, OE_LANE1);
        frame(OP_DUAL_IO_WIDE, 1, 32'hf012_3456, 4, 2, 32'h0, 4,
              OE_LANE2);
        $display("Test dual done");
    endtask

    // Later passes set quad enable, DTR and reset-pin mode; each kills the pause
    task automatic t_hold();
        cs_n <= 1'b0;
        repeat (4) @(posedge pclk);
        send({OP_FAST_READ, 24'hffffff}, 13, 1);
        cs_n <= 1'b1;
        repeat (8) @(posedge pclk);
        for (int q = 0; q < 4; q++)
        begin
            apb(1'b1, REG_CTRL, (q == 0) ? 32'h0 : (32'h2 << q));
            cs_n <= 1'b0;
            repeat (4) @(posedge pclk);
            send({OP_FAST_READ, 24'h0}, 8, 1);
            send(32'h0002_0000, 24, 1);
            send(32'h0, 8, 1);
            rx(28'h200, 1, 1, OE_LANE1);
            sck <= 1'b0;
            repeat (4) @(posedge pclk);
            io_in <= 4'h0;
            repeat (8) @(posedge pclk);
            repeat ((q == 0) ? 2 : 0)
            begin
                sck <= 1'b1;
                repeat (8) @(posedge pclk);
                sck <= 1'b0;
                repeat (8) @(posedge pclk);
            end
            chk({28'h0, io_oe_n},
                {28'h0, (q == 0) ? OE_NONE : OE_LANE1});
            io_in <= 4'h8;
            repeat (4) @(posedge pclk);
            rx(28'h201, 1, 1, OE_LANE1);
            cs_n <= 1'b1;
            repeat (8) @(posedge pclk);
        end
        $display("Test hold done");
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cs_n = 1'b1;
        sck = 1'b1;
        io_in = 4'h8;
        errors = 0;
        cmp_count = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs();
        t_single();
        t_quad();
        t_dual();
        t_hold();
        tally_and_finish();
    end
endmodule
